// File: ovp_regs.vh
// Summary of operation
// - supervise fundamental line-to-line magnitudes only, whatever the measurement mode
// - supervised value is the largest of the three magnitudes, readable
// - stage starts whenever the maximum exceeds its pick-up setting and the stage is not blocked
// - stage trips once the fault lasted longer than its operate time
// - three stages, each with own pick-up level and own operate delay
// - operate delay is a fixed time independent of overvoltage size
// - pick-up set in percent of rated voltage, also reported in primary volts
// - first stage timer holds on clearing, resets after release delay
// - fault returning within release delay resumes timer from held value
// - fault holds until voltage falls below pick-up minus dead band, default 3 %
// - four setting groups per stage, active group is reported
// - group switched manually or by digital or virtual signals
// - selector picks group signal: none, digital, virtual, indicator, virtual output
// - one shared test-force flag, cleared by itself after five minutes
// - each stage reports idle, blocked, started or tripped
// - last eight fault ends, one per cycle from the lowest ending stage, keep time stamp, peak voltage, elapsed fraction, group
`ifndef OVP_REGS_VH
`define OVP_REGS_VH
`define OVP_A_CTRL 8'h00
`define OVP_A_GSRC 8'h01
`define OVP_A_STAT 8'h02
`define OVP_A_UMAX 8'h03
`define OVP_A_IRQ_ST 8'h04
`define OVP_A_IRQ_MSK 8'h05
`define OVP_A_RATED 8'h06
`define OVP_A_FORCE 8'h07
`define OVP_A_SCNT 8'h08
`define OVP_A_TCNT 8'h0C
`define OVP_A_STG 8'h10
`define OVP_A_PRIPU 8'h14
`define OVP_A_SET_LO 8'h20
`define OVP_A_SET_HI 8'h4F
`define OVP_A_FSEL 8'h50
`define OVP_A_FTIME 8'h51
`define OVP_A_FDATA 8'h52
`define OVP_CTRL_MGRP 0
`define OVP_CTRL_AGRP 2
`define OVP_CTRL_FORCE 4
`define OVP_CTRL_CLR 5
`define OVP_CTRL_BLK 8
`define OVP_GSRC_SRC 0
`define OVP_GSRC_IDX 4
`define OVP_SRC_NONE 3'h0
`define OVP_SRC_DI 3'h1
`define OVP_SRC_VI 3'h2
`define OVP_SRC_LED 3'h3
`define OVP_SRC_VO 3'h4
`define OVP_ST_IDLE 2'h0
`define OVP_ST_BLOCKED 2'h1
`define OVP_ST_STARTED 2'h2
`define OVP_ST_TRIPPED 2'h3
`define OVP_PICK_DEF 16'h2EE0
`define OVP_OPTM_DEF 16'h03E8
`define OVP_HYST_DEF 8'h1E
`define OVP_RLS_DEF 16'h0000
`define OVP_RATED_DEF 16'h2710
`define OVP_HYST_DIV 24'h0003E8
`define OVP_PCT_DIV 32'h00002710
`define OVP_ELAPSED_DELAY_FRACTION_FULL 7'h64
`define OVP_TICK_CYC 16'h9C40
`define OVP_FORCE_MS 19'h493E0
`endif

// File: ovp_fault_mem.v
// eight-entry fault record store, registered read port
module ovp_fault_mem (
	input wire clock,
	input wire wr_en,
	input wire [2:0] wr_addr,
	input wire [63:0] wr_data,
	input wire [2:0] rd_addr,
	output reg [63:0] rd_data
);
	reg [63:0] mem [0:7];

	// write and registered read share one edge
	always @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // ovp_fault_mem

// File: ovp_top.v
`include "ovp_regs.vh"
module ovp_top #(
	parameter [15:0] TICK_CYCLES = `OVP_TICK_CYC, // 1 ms of 25 ns cycles
	parameter [18:0] FORCE_TICKS = `OVP_FORCE_MS
) (
	input wire clock,
	input wire srst,
	input wire [15:0] u12,
	input wire [15:0] u23,
	input wire [15:0] u31,
	input wire [7:0] digital_input_n,
	input wire [7:0] virtual_input_n,
	input wire [7:0] indicator_signal_n,
	input wire [7:0] virtual_output_n,
	input wire [2:0] block_in,
	input wire [31:0] time_stamp,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [31:0] rdata,
	output reg [2:0] start_out,
	output reg [2:0] trip_out,
	output reg [1:0] active_setting_group,
	output reg force_flag,
	output reg irq
);
	integer i;
	integer k;
	integer i_t;
	integer i_o;
	integer i_w;
	reg [15:0] pick_r [0:11];
	reg [15:0] optm_r [0:11];
	reg [7:0] hyst_r [0:11];
	reg [15:0] rls_r [0:3];
	reg [10:0] ctrl_r;
	reg [6:0] gsrc_r;
	reg [15:0] rated_r;
	reg [5:0] fsel_r;
	reg [5:0] irq_st_r;
	reg [5:0] irq_msk_r;
	reg [2:0] frec_sel_r;
	reg [15:0] umax_r;
	reg [7:0] di_s1_r;
	reg [7:0] di_s2_r;
	reg [15:0] tick_cnt_r;
	reg tick_r;
	reg [18:0] force_cnt_r;
	reg [2:0] fault_r;
	reg [15:0] timer_r [0:2];
	reg [15:0] rls_cnt_r;
	reg [15:0] peak_r [0:2];
	reg [15:0] scnt_r [0:2];
	reg [15:0] tcnt_r [0:2];
	reg [2:0] wp_r;
	reg mem_we_r;
	reg [63:0] mem_wd_r;
	wire [63:0] mem_rd;
	reg [15:0] cur_pick [0:2];
	reg [15:0] cur_optm [0:2];
	reg [15:0] rel_thr [0:2];
	reg [2:0] start_nxt;
	reg [2:0] trip_nxt;
	reg [2:0] fault_end;
	reg [2:0] blk;
	reg [1:0] stg_st [0:2];
	reg sel_bit;
	reg [7:0] sel_vec;
	reg [23:0] hprod;
	reg [23:0] hquo;
	reg [23:0] eprod;
	reg [6:0] elapsed_delay_fraction;
	reg [22:0] equo;
	reg [1:0] rec_s;
	reg rec_any;
	reg [31:0] rd_nxt;
	reg [31:0] pprod;
	wire set_hit;
	wire [3:0] set_k;
	wire ctrl_wr;
	wire cnt_clr;

	// largest of three magnitudes
	function [15:0] max3;
		input [15:0] a;
		input [15:0] b;
		input [15:0] c;
		reg [15:0] m;
		begin
			m = (a > b) ? a : b;
			max3 = (m > c) ? m : c;
		end
	endfunction

	// setting address to stage*4+group index
	function [3:0] set_index;
		input [7:0] a;
		reg [2:0] s;
		begin
			s = a[6:4] - 3'h2;
			set_index = {s[1:0], a[3:2]};
		end
	endfunction

	assign set_hit = (addr >= `OVP_A_SET_LO) && (addr <= `OVP_A_SET_HI);
	assign set_k = set_index(addr);
	assign ctrl_wr = wr_en && (addr == `OVP_A_CTRL);
	assign cnt_clr = ctrl_wr && wdata[`OVP_CTRL_CLR];

	// digital inputs come from pins, two flops before use
	always @(posedge clock) begin
		if (srst) begin
			di_s1_r <= 8'h00;
			di_s2_r <= 8'h00;
		end else begin
			di_s1_r <= digital_input_n;
			di_s2_r <= di_s1_r;
		end
	end

	// millisecond tick; all delays count in these steps
	always @(posedge clock) begin
		if (srst) begin
			tick_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (tick_cnt_r == TICK_CYCLES - 16'h0001) begin
			tick_cnt_r <= 16'h0000;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// supervised maximum, line-to-line only so earth faults cannot lift it
	always @(posedge clock) begin
		if (srst) begin
			umax_r <= 16'h0000;
		end else begin
			umax_r <= max3(u12, u23, u31);
		end
	end

	// group select signal picked by source and bit index
	always @* begin
		case (gsrc_r[2:0])
			`OVP_SRC_DI: sel_vec = di_s2_r;
			`OVP_SRC_VI: sel_vec = virtual_input_n;
			`OVP_SRC_LED: sel_vec = indicator_signal_n;
			`OVP_SRC_VO: sel_vec = virtual_output_n;
			default: sel_vec = 8'h00;
		endcase
		sel_bit = sel_vec[gsrc_r[6:4]];
	end

	// active group: manual, or alternate while the chosen signal is high
	always @(posedge clock) begin
		if (srst) begin
			active_setting_group <= 2'h0;
		end else if (sel_bit) begin
			active_setting_group <= ctrl_r[3:2];
		end else begin
			active_setting_group <= ctrl_r[1:0];
		end
	end

	// per stage settings of the active group and release threshold
	always @* begin
		for (i = 0; i < 3; i = i + 1) begin
			k = i * 4 + active_setting_group;
			cur_pick[i] = pick_r[k];
			cur_optm[i] = optm_r[k];
			hprod = cur_pick[i] * hyst_r[k];
			// full product before dividing; it overflows 16 bits at normal settings
			hquo = hprod / `OVP_HYST_DIV;
			rel_thr[i] = cur_pick[i] - hquo[15:0];
			blk[i] = block_in[i] | ctrl_r[`OVP_CTRL_BLK + i];
			fault_end[i] = fault_r[i] && (umax_r < rel_thr[i]);
			start_nxt[i] = (fault_r[i] && !blk[i]) || (force_flag && fsel_r[i]);
			trip_nxt[i] = (fault_r[i] && !blk[i] && timer_r[i] >= cur_optm[i])
				|| (force_flag && fsel_r[3 + i]);
			if (blk[i]) begin
				stg_st[i] = `OVP_ST_BLOCKED;
			end else if (trip_out[i]) begin
				stg_st[i] = `OVP_ST_TRIPPED;
			end else if (start_out[i]) begin
				stg_st[i] = `OVP_ST_STARTED;
			end else begin
				stg_st[i] = `OVP_ST_IDLE;
			end
		end
	end

	// stage fault state, delay timers and release timer
	always @(posedge clock) begin
		if (srst) begin
			fault_r <= 3'h0;
			rls_cnt_r <= 16'h0000;
			for (i_t = 0; i_t < 3; i_t = i_t + 1) begin
				timer_r[i_t] <= 16'h0000;
				peak_r[i_t] <= 16'h0000;
			end
		end else begin
			for (i_t = 0; i_t < 3; i_t = i_t + 1) begin
				if (fault_end[i_t]) begin
					fault_r[i_t] <= 1'b0;
				end else if (!fault_r[i_t] && umax_r > cur_pick[i_t]) begin
					fault_r[i_t] <= 1'b1;
					peak_r[i_t] <= umax_r;
				end else if (fault_r[i_t] && umax_r > peak_r[i_t]) begin
					peak_r[i_t] <= umax_r;
				end
				if (blk[i_t]) begin
					timer_r[i_t] <= timer_r[i_t];
				end else if (fault_r[i_t]) begin
					if (tick_r && timer_r[i_t] < cur_optm[i_t]) begin
						timer_r[i_t] <= timer_r[i_t] + 16'h0001;
					end
				end else if (i_t != 0) begin
					timer_r[i_t] <= 16'h0000;
				end else if (rls_cnt_r >= rls_r[active_setting_group]) begin
					timer_r[i_t] <= 16'h0000;
				end
			end
			// release timer only while stage one has retained time
			if (fault_r[0] || timer_r[0] == 16'h0000) begin
				rls_cnt_r <= 16'h0000;
			end else if (tick_r && !blk[0]) begin
				rls_cnt_r <= rls_cnt_r + 16'h0001;
			end
		end
	end

	// outputs, counters and interrupt flags
	always @(posedge clock) begin
		if (srst) begin
			start_out <= 3'h0;
			trip_out <= 3'h0;
			irq_st_r <= 6'h00;
			irq <= 1'b0;
			for (i_o = 0; i_o < 3; i_o = i_o + 1) begin
				scnt_r[i_o] <= 16'h0000;
				tcnt_r[i_o] <= 16'h0000;
			end
		end else begin
			start_out <= start_nxt;
			trip_out <= trip_nxt;
			for (i_o = 0; i_o < 3; i_o = i_o + 1) begin
				if (start_nxt[i_o] && !start_out[i_o]) begin
					scnt_r[i_o] <= cnt_clr ? 16'h0001 : scnt_r[i_o] + 16'h0001;
				end else if (cnt_clr) begin
					scnt_r[i_o] <= 16'h0000;
				end
				if (trip_nxt[i_o] && !trip_out[i_o]) begin
					tcnt_r[i_o] <= cnt_clr ? 16'h0001 : tcnt_r[i_o] + 16'h0001;
				end else if (cnt_clr) begin
					tcnt_r[i_o] <= 16'h0000;
				end
			end
			// new events win over a write-one clear in the same cycle
			if (wr_en && addr == `OVP_A_IRQ_ST) begin
				irq_st_r <= (irq_st_r & ~wdata[5:0])
					| {trip_nxt & ~trip_out, start_nxt & ~start_out};
			end else begin
				irq_st_r <= irq_st_r | {trip_nxt & ~trip_out, start_nxt & ~start_out};
			end
			irq <= |(irq_st_r & irq_msk_r);
		end
	end

	// test force flag, shared, times out by itself
	always @(posedge clock) begin
		if (srst) begin
			force_flag <= 1'b0;
			force_cnt_r <= 19'h00000;
		end else if (ctrl_wr) begin
			force_flag <= wdata[`OVP_CTRL_FORCE];
			force_cnt_r <= 19'h00000;
		end else if (force_flag && tick_r) begin
			if (force_cnt_r == FORCE_TICKS - 19'h00001) begin
				force_flag <= 1'b0;
				force_cnt_r <= 19'h00000;
			end else begin
				force_cnt_r <= force_cnt_r + 19'h00001;
			end
		end
	end

	// pick lowest ending stage for recording; simultaneous ends drop the rest
	always @* begin
		rec_any = |fault_end;
		if (fault_end[0]) begin
			rec_s = 2'h0;
		end else if (fault_end[1]) begin
			rec_s = 2'h1;
		end else begin
			rec_s = 2'h2;
		end
		eprod = timer_r[rec_s] * 8'h64;
		equo = 23'h000000;
		if (cur_optm[rec_s] == 16'h0000 || timer_r[rec_s] >= cur_optm[rec_s]) begin
			elapsed_delay_fraction = `OVP_ELAPSED_DELAY_FRACTION_FULL;
		end else begin
			equo = eprod[22:0] / cur_optm[rec_s];
			elapsed_delay_fraction = equo[6:0]; // below 100 here, since timer < operate time
		end
	end

	// fault record write, ring of eight
	always @(posedge clock) begin
		if (srst) begin
			wp_r <= 3'h0;
			mem_we_r <= 1'b0;
			mem_wd_r <= 64'h0000000000000000;
		end else begin
			mem_we_r <= rec_any;
			if (rec_any) begin
				mem_wd_r <= {time_stamp, 5'h00, rec_s, active_setting_group, elapsed_delay_fraction,
					peak_r[rec_s]};
			end
			if (mem_we_r) begin
				wp_r <= wp_r + 3'h1;
			end
		end
	end

	ovp_fault_mem u_mem (
		.clock(clock),
		.wr_en(mem_we_r),
		.wr_addr(wp_r),
		.wr_data(mem_wd_r),
		.rd_addr(frec_sel_r),
		.rd_data(mem_rd)
	);

	// register writes
	always @(posedge clock) begin
		if (srst) begin
			ctrl_r <= 11'h000;
			gsrc_r <= 7'h00;
			rated_r <= `OVP_RATED_DEF;
			fsel_r <= 6'h00;
			irq_msk_r <= 6'h00;
			frec_sel_r <= 3'h0;
			for (i_w = 0; i_w < 12; i_w = i_w + 1) begin
				pick_r[i_w] <= `OVP_PICK_DEF;
				optm_r[i_w] <= `OVP_OPTM_DEF;
				hyst_r[i_w] <= `OVP_HYST_DEF;
			end
			for (i_w = 0; i_w < 4; i_w = i_w + 1) begin
				rls_r[i_w] <= `OVP_RLS_DEF;
			end
		end else if (wr_en) begin
			if (addr == `OVP_A_CTRL) begin
				ctrl_r <= {wdata[10:8], 4'h0, wdata[3:0]};
			end
			if (addr == `OVP_A_GSRC) begin
				gsrc_r <= {wdata[6:4], 1'b0, wdata[2:0]};
			end
			if (addr == `OVP_A_RATED) begin
				rated_r <= wdata[15:0];
			end
			if (addr == `OVP_A_FORCE) begin
				fsel_r <= wdata[5:0];
			end
			if (addr == `OVP_A_IRQ_MSK) begin
				irq_msk_r <= wdata[5:0];
			end
			if (addr == `OVP_A_FSEL) begin
				frec_sel_r <= wdata[2:0];
			end
			if (set_hit) begin
				case (addr[1:0])
					2'h0: pick_r[set_k] <= wdata[15:0];
					2'h1: optm_r[set_k] <= wdata[15:0];
					2'h2: hyst_r[set_k] <= wdata[7:0];
					default: begin
						if (set_k[3:2] == 2'h0) begin
							rls_r[set_k[1:0]] <= wdata[15:0];
						end
					end
				endcase
			end
		end
	end

	// read mux; unmapped reads as zero
	always @* begin
		rd_nxt = 32'h00000000;
		pprod = 32'h00000000;
		if (addr[7:2] == 6'h02 && addr[1:0] != 2'h3) begin
			rd_nxt = {16'h0000, scnt_r[addr[1:0]]};
		end else if (addr[7:2] == 6'h03 && addr[1:0] != 2'h3) begin
			rd_nxt = {16'h0000, tcnt_r[addr[1:0]]};
		end else if (addr[7:2] == 6'h04 && addr[1:0] != 2'h3) begin
			rd_nxt = {30'h00000000, stg_st[addr[1:0]]};
		end else if (addr[7:2] == 6'h05 && addr[1:0] != 2'h3) begin
			pprod = cur_pick[addr[1:0]] * rated_r;
			rd_nxt = pprod / `OVP_PCT_DIV;
		end else if (set_hit) begin
			case (addr[1:0])
				2'h0: rd_nxt = {16'h0000, pick_r[set_k]};
				2'h1: rd_nxt = {16'h0000, optm_r[set_k]};
				2'h2: rd_nxt = {24'h000000, hyst_r[set_k]};
				default: rd_nxt = (set_k[3:2] == 2'h0) ? {16'h0000, rls_r[set_k[1:0]]}
					: 32'h00000000;
			endcase
		end else begin
			case (addr)
				`OVP_A_CTRL: rd_nxt = {21'h000000, ctrl_r[10:5], force_flag, ctrl_r[3:0]};
				`OVP_A_GSRC: rd_nxt = {25'h0000000, gsrc_r};
				`OVP_A_STAT: rd_nxt = {29'h00000000, force_flag, active_setting_group};
				`OVP_A_UMAX: rd_nxt = {16'h0000, umax_r};
				`OVP_A_IRQ_ST: rd_nxt = {26'h0000000, irq_st_r};
				`OVP_A_IRQ_MSK: rd_nxt = {26'h0000000, irq_msk_r};
				`OVP_A_RATED: rd_nxt = {16'h0000, rated_r};
				`OVP_A_FORCE: rd_nxt = {26'h0000000, fsel_r};
				`OVP_A_FSEL: rd_nxt = {29'h00000000, frec_sel_r};
				`OVP_A_FTIME: rd_nxt = mem_rd[63:32];
				`OVP_A_FDATA: rd_nxt = mem_rd[31:0];
				default: rd_nxt = 32'h00000000;
			endcase
		end
	end

	// read data stand for one cycle only
	always @(posedge clock) begin
		if (srst) begin
			rdata <= 32'h00000000;
		end else if (rd_en) begin
			rdata <= rd_nxt;
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule // ovp_top

// File: ovp_line_src.sv
// far-side front end: three line-to-line magnitudes, one pair lifted to a test level
module ovp_line_src (
	input wire clock,
	input wire [15:0] level,
	input wire [1:0] pair,
	input wire [15:0] base,
	output logic [15:0] u12 = 16'h0000,
	output logic [15:0] u23 = 16'h0000,
	output logic [15:0] u31 = 16'h0000
);
	timeunit 1ns;
	timeprecision 100ps;
	// only line-to-line values exist here, so phase-to-ground rises never reach the block
	always @(posedge clock) begin
		u12 <= (pair == 2'h0) ? level : base;
		u23 <= (pair == 2'h1) ? level : base;
		u31 <= (pair == 2'h2) ? level : base;
	end
endmodule // ovp_line_src

// File: ovp_chk_sva.sv
module ovp_chk #(
	parameter [15:0] TICK_CYCLES = 16'h0004,
	parameter [18:0] FORCE_TICKS = 19'h00005
) (
	input wire clock,
	input wire srst,
	input wire [15:0] u12,
	input wire [15:0] u23,
	input wire [15:0] u31,
	input wire [7:0] digital_input_n,
	input wire [7:0] virtual_input_n,
	input wire [7:0] indicator_signal_n,
	input wire [7:0] virtual_output_n,
	input wire [2:0] block_in,
	input wire wr_en,
	input wire rd_en,
	input wire [31:0] rdata,
	input wire [2:0] start_out,
	input wire [2:0] trip_out,
	input wire [1:0] active_setting_group,
	input wire force_flag,
	input wire irq
);
	timeunit 1ns;
	timeprecision 100ps;
	// force budget: all ticks, one partial tick, latency; overflows with full-size counts
	localparam int FLIM = FORCE_TICKS * TICK_CYCLES + TICK_CYCLES + 4;
	logic [31:0] frc_cnt_r;
	default clocking @(posedge clock);
	endclocking
	default disable iff (srst);
	// time the force flag has stood since the last write
	always_ff @(posedge clock) begin
		if (srst || !force_flag || wr_en) begin
			frc_cnt_r <= 32'h0;
		end else begin
			frc_cnt_r <= frc_cnt_r + 32'h1;
		end
	end
	property p_rdata_idle;
		!$past(rd_en) |-> rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read slot");
	property p_zero_v;
		(u12 == 16'h0 && u23 == 16'h0 && u31 == 16'h0 && !force_flag)[*5] |-> start_out == 3'h0;
	endproperty
	a_zero_v: assert property (p_zero_v)
		else $error("start without voltage");
	property p_trip_start;
		!force_flag && !$past(force_flag) |-> (trip_out & ~start_out) == 3'h0;
	endproperty
	a_trip_start: assert property (p_trip_start)
		else $error("trip without start");
	property p_block;
		(!force_flag)[*3] |->
			((start_out | trip_out) & block_in & $past(block_in) & $past(block_in, 2)) == 3'h0;
	endproperty
	a_block: assert property (p_block)
		else $error("blocked stage active");
	property p_force_rise;
		$rose(force_flag) |-> $past(wr_en);
	endproperty
	a_force_rise: assert property (p_force_rise)
		else $error("force set without write");
	property p_force_to;
		frc_cnt_r <= FLIM;
	endproperty
	a_force_to: assert property (p_force_to)
		else $error("force flag outlived timeout");
	property p_irq_fall;
		$fell(irq) |-> $past(wr_en, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("irq fell without write");
	property p_grp;
		(!wr_en && $stable(digital_input_n) && $stable(virtual_input_n)
			&& $stable(indicator_signal_n) && $stable(virtual_output_n))[*5]
			|-> $stable(active_setting_group);
	endproperty
	a_grp: assert property (p_grp)
		else $error("group changed with no cause");
endmodule // ovp_chk
bind ovp_top ovp_chk #(.TICK_CYCLES(TICK_CYCLES), .FORCE_TICKS(FORCE_TICKS)) u_chk (
	.clock(clock), .srst(srst), .u12(u12), .u23(u23), .u31(u31),
	.digital_input_n(digital_input_n), .virtual_input_n(virtual_input_n),
	.indicator_signal_n(indicator_signal_n), .virtual_output_n(virtual_output_n),
	.block_in(block_in), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
	.start_out(start_out), .trip_out(trip_out), .active_setting_group(active_setting_group),
	.force_flag(force_flag), .irq(irq));

// File: tb_ovp_top.sv
module tb_ovp_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [15:0] lvl = 16'h0000;
	logic [1:0] pair = 2'h0;
	logic [15:0] base = 16'h0000;
	logic [7:0] src_v [0:3] = '{8'h00, 8'h00, 8'h00, 8'h00};
	logic [2:0] blk = 3'h0;
	logic [31:0] stamp = 32'h00000000;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rv;
	wire [15:0] u12;
	wire [15:0] u23;
	wire [15:0] u31;
	wire [31:0] rdata;
	wire [2:0] start_out;
	wire [2:0] trip_out;
	wire [1:0] grp;
	wire force_flag;
	wire irq;
	int err_total = 0;
	int compares = 0;
	// 25 ns clock
	initial begin
		forever #12.5 clock = ~clock;
	end
	// free-running stamp for fault records
	always @(posedge clock) begin
		stamp <= stamp + 32'h00000001;
	end
	ovp_line_src src (.clock(clock), .level(lvl), .pair(pair), .base(base),
		.u12(u12), .u23(u23), .u31(u31));
	ovp_top #(.TICK_CYCLES(16'h0004), .FORCE_TICKS(19'h00005)) dut (.clock(clock),
		.srst(srst), .u12(u12), .u23(u23), .u31(u31), .digital_input_n(src_v[0]),
		.virtual_input_n(src_v[1]), .indicator_signal_n(src_v[2]),
		.virtual_output_n(src_v[3]), .block_in(blk), .time_stamp(stamp), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .start_out(start_out),
		.trip_out(trip_out), .active_setting_group(grp), .force_flag(force_flag), .irq(irq));
	task automatic complete_run;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
		end
	endtask
	// waits end just after an edge so outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic guard(input int n);
		if (n > 300) begin
			err_total++;
			$display("unexpected at %0t: wait ran out", $time);
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string w);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 rv = rdata;
		chk(rv, e, w);
	endtask
	task automatic volt(input logic [15:0] v, input int hold);
		@(posedge clock);
		lvl <= v;
		cyc(hold);
	endtask
	task automatic wait_out(input int s, input bit t, output int n);
		n = 0;
		while ((t ? trip_out[s] : start_out[s]) !== 1'b1) begin
			cyc(1);
			n++;
			guard(n);
		end
	endtask
	task automatic t_defaults;
		rc(8'h20, 32'h2EE0, "pick def");
		rc(8'h21, 32'h03E8, "optm def");
		rc(8'h22, 32'h001E, "hyst def");
		rc(8'h06, 32'h2710, "rated def");
		wr(8'h06, 32'h4E20);
		rc(8'h14, 32'h5DC0, "primary pick");
		wr(8'h60, 32'h0055);
		rc(8'h60, 32'h0, "unmapped");
		$display("done defaults");
	endtask
	task automatic t_umax;
		for (int p = 0; p < 3; p++) begin
			@(posedge clock);
			base <= 16'h1388;
			pair <= p[1:0];
			volt(16'h1B58, 4);
			rc(8'h03, 32'h1B58, "umax");
		end
		@(posedge clock);
		pair <= 2'h1;
		base <= 16'h2710;
		volt(16'h2710, 2);
		$display("done umax");
	endtask
	task automatic t_trip;
		int n;
		wr(8'h20, 32'h3A98);
		wr(8'h40, 32'h3A98);
		wr(8'h31, 32'h2);
		wr(8'h05, 32'h3F);
		volt(16'h30D4, 0);
		wait_out(1, 0, n);
		chk(start_out, 3'h2, "one stage");
		wait_out(1, 1, n);
		chk(n >= 3 && n <= 14, 1'b1, "operate delay");
		rc(8'h11, 32'h3, "status trip");
		chk(irq, 1'b1, "irq up");
		volt(16'h2DB4, 12);
		chk(start_out[1], 1'b1, "dead band");
		volt(16'h2D50, 6);
		chk(start_out, 3'h0, "released");
		rc(8'h09, 32'h1, "start count");
		rc(8'h0D, 32'h1, "trip count");
		rc(8'h04, 32'h12, "irq status");
		wr(8'h50, 32'h0);
		cyc(2);
		rc(8'h52, 32'h026430D4, "record");
		wr(8'h04, 32'h12);
		cyc(3);
		chk(irq, 1'b0, "irq clear");
		wr(8'h00, 32'h20);
		rc(8'h09, 32'h0, "count clear");
		$display("done trip");
	endtask
	task automatic t_release;
		int n;
		wr(8'h30, 32'h3A98);
		wr(8'h20, 32'h2EE0);
		wr(8'h21, 32'hA);
		wr(8'h23, 32'h5);
		volt(16'h30D4, 24);
		chk(trip_out[0], 1'b0, "early trip");
		volt(16'h2710, 8);
		volt(16'h30D4, 0);
		wait_out(0, 1, n);
		chk(n <= 30, 1'b1, "timer resumed");
		volt(16'h2710, 48);
		volt(16'h30D4, 24);
		chk(trip_out[0], 1'b0, "timer reset");
		volt(16'h2710, 8);
		$display("done release");
	endtask
	// masked event must not raise irq until the mask opens
	task automatic t_block;
		int n;
		wr(8'h20, 32'h3A98);
		wr(8'h40, 32'h2EE0);
		wr(8'h05, 32'h0);
		wr(8'h04, 32'h3F);
		@(posedge clock);
		blk <= 3'h4;
		volt(16'h30D4, 10);
		chk(start_out, 3'h0, "blocked");
		rc(8'h12, 32'h1, "status block");
		@(posedge clock);
		blk <= 3'h0;
		wait_out(2, 0, n);
		rc(8'h12, 32'h2, "status start");
		chk(irq, 1'b0, "irq masked");
		wr(8'h05, 32'h04);
		cyc(2);
		chk(irq, 1'b1, "irq unmasked");
		wr(8'h00, 32'h400);
		cyc(2);
		chk(start_out, 3'h0, "ctrl block");
		rc(8'h12, 32'h1, "status ctrl block");
		wr(8'h00, 32'h0);
		volt(16'h2710, 6);
		rc(8'h12, 32'h0, "status idle");
		wr(8'h04, 32'h3F);
		$display("done block");
	endtask
	task automatic t_group;
		for (int s = 1; s < 5; s++) begin
			wr(8'h01, {25'h0, 3'h3, 1'b0, s[2:0]});
			wr(8'h00, 32'h8);
			@(posedge clock);
			src_v[s-1] <= 8'h08;
			cyc(5);
			chk(grp, 2'h2, "alt group");
			@(posedge clock);
			src_v[s-1] <= 8'h00;
			cyc(5);
			chk(grp, 2'h0, "manual group");
		end
		wr(8'h01, 32'h30);
		wr(8'h2C, 32'h3A98);
		wr(8'h00, 32'h0B);
		@(posedge clock);
		src_v[0] <= 8'hFF;
		cyc(5);
		chk(grp, 2'h3, "source none");
		rc(8'h02, 32'h3, "status group");
		rc(8'h14, 32'h7530, "group pick");
		@(posedge clock);
		src_v[0] <= 8'h00;
		wr(8'h00, 32'h0);
		$display("done group");
	endtask
	task automatic t_force;
		int n;
		wr(8'h00, 32'h10);
		wr(8'h07, 32'h09);
		cyc(2);
		chk({trip_out, start_out}, 6'h09, "forced");
		n = 0;
		while (force_flag !== 1'b0) begin
			cyc(1);
			n++;
			guard(n);
		end
		chk(n >= 10 && n <= 26, 1'b1, "force timeout");
		cyc(2);
		chk({trip_out, start_out}, 6'h00, "unforced");
		$display("done force");
	endtask
	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		t_defaults();
		t_umax();
		t_trip();
		t_release();
		t_block();
		t_group();
		t_force();
		complete_run();
	end
endmodule // tb_ovp_top
